// >>> pct_access_bank.v
// PHY register access port, isochronous cycle timer and async request
// filter. Assumes register port, PHY port and packet inputs are on clk;
// only the external cycle pin is asynchronous.
//
// Behaviour
// [R01] Transfer-complete flag clears when software sets read or write request.
// [R02] Transfer-complete flag sets when the PHY returns a register transfer.
// [R03] Returned address and value are captured; software cannot write them.
// [R04] Read request bit sends a PHY read, cleared once it is sent.
// [R05] Write request bit sends a PHY write with data, cleared once sent.
// [R06] Software never sets read and write requests together.
// [R07] Target address and write data are read/write; data unused on reads.
// [R08] Seconds count cycle-counter rollovers modulo 128.
// [R09] Cycle counter counts offset rollovers modulo 8000.
// [R10] Offset counts 24.576 MHz ticks modulo 3072.
// [R11] External 8 kHz tick forces the offset to zero.
// [R12] As cycle master, the timer value goes into each sent cycle start.
// [R13] When not master, incoming cycle start data loads the timer.
// [R14] Without cycle starts, the timer keeps counting when enabled.
// [R15] Filtered contexts drop packets whose source filter bit is clear.
// [R16] Only local-bus sources are node-checked; remote need all-buses bit.
// [R17] Upper filter bits 30..0 admit local nodes 62..32.
// [R18] Lower filter bit n admits local node n.
// [R19] Upper filter at set 100h, clear 104h; lower at 108h, 10Ch.
// [R20] Ones set or clear filter bits; zeros no effect; reads show value.
// [R21] External cycle select uses the cycle pin for rollover, not 3072.
`default_nettype none
`include "pct_consts.vh"

module pct_access_bank (
    input wire clk,                      // 100 MHz system clock
    input wire rst_n,                    // Async reset, active low
    input wire regWrEn,                  // Register write strobe
    input wire regRdEn,                  // Register read strobe
    input wire [`PCT_ADDR_W-1:0] target_phy_reg_address, // Register byte address
    input wire [31:0] regWrData,         // Register write data
    output reg [31:0] regRdData_q,       // Register read data
    output reg regRdValid_q,             // Read data valid pulse
    output reg phyReqValid_q,            // PHY request pending
    input wire phyReqReady,              // PHY takes the request
    output reg phyReqWrite_q,            // One for write, zero for read
    output reg [3:0] phyReqAddr_q,       // PHY register address
    output reg [7:0] phyReqData_q,       // PHY write value
    input wire phyRetValid,              // PHY returns a register
    input wire [3:0] phyRetAddr,         // Returned register address
    input wire [7:0] phyRetData,         // Returned register value
    input wire cycleMasterEnable,        // Node acts as cycle master
    input wire externalCycleSelect,      // Rollover from the cycle pin
    input wire cycleTimerEnable,         // Offset counting enabled
    input wire externalCycleInput,       // 8 kHz pin, asynchronous
    input wire cycStartRxValid,          // Cycle start packet received
    input wire [31:0] cycStartRxData,    // Its cycle time data
    output reg cycStartTxValid_q,        // Send a cycle start now
    output reg [31:0] cycStartTxData_q,  // Cycle time to send
    input wire [9:0] localBusNumber,     // This node's bus number
    input wire filtReqValid,             // Packet to check
    input wire filtCtxHit,               // Bound for phys or async rx
    input wire [15:0] filtSrcId,         // Source bus and node
    output reg filtDoneValid_q,          // Decision valid pulse
    output reg filtAccept_q              // Acknowledge and queue
);

    // ****************************************
    // Register decode
    // ****************************************
    wire wrPhy = regWrEn && (target_phy_reg_address == `PCT_A_PHY);
    wire wrTimer = regWrEn && (target_phy_reg_address == `PCT_A_TIMER);
    wire wrHiSet = regWrEn && (target_phy_reg_address == `PCT_A_HI_SET);
    wire wrHiClr = regWrEn && (target_phy_reg_address == `PCT_A_HI_CLR);
    wire wrLoSet = regWrEn && (target_phy_reg_address == `PCT_A_LO_SET);
    wire wrLoClr = regWrEn && (target_phy_reg_address == `PCT_A_LO_CLR);

    // ****************************************
    // PHY access register
    // ****************************************
    reg done_q;
    reg [3:0] retAddr_q;
    reg [7:0] retData_q;
    reg rdReq_q;
    reg wrReq_q;
    reg [3:0] tgtAddr_q;
    reg [7:0] wrVal_q;

    wire reqSent = phyReqValid_q && phyReqReady;
    wire swStart = wrPhy && (regWrData[`PCT_B_RDREQ] ||
        regWrData[`PCT_B_WRREQ]);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            retAddr_q <= 4'h0;
            retData_q <= 8'h00;
        end else if (phyRetValid) begin
            // Return in the same cycle as a start keeps the flag set
            done_q <= 1'b1;                         // [R02]
            retAddr_q <= phyRetAddr;                // [R03]
            retData_q <= phyRetData;                // [R03]
        end else if (swStart) begin
            done_q <= 1'b0;                         // [R01]
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdReq_q <= 1'b0;
            wrReq_q <= 1'b0;
            tgtAddr_q <= 4'h0;
            wrVal_q <= 8'h00;
        end else if (wrPhy) begin
            rdReq_q <= regWrData[`PCT_B_RDREQ];
            wrReq_q <= regWrData[`PCT_B_WRREQ];
            tgtAddr_q <= regWrData[`PCT_F_TADDR];   // [R07]
            wrVal_q <= regWrData[`PCT_F_WDATA];     // [R07]
        end else if (reqSent) begin
            rdReq_q <= 1'b0;                        // [R04]
            wrReq_q <= 1'b0;                        // [R05]
        end
    end

    // Request is launched once and held until the PHY takes it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phyReqValid_q <= 1'b0;
            phyReqWrite_q <= 1'b0;
            phyReqAddr_q <= 4'h0;
            phyReqData_q <= 8'h00;
        end else if (reqSent) begin
            phyReqValid_q <= 1'b0;
        end else if (!phyReqValid_q && (rdReq_q || wrReq_q) && !wrPhy) begin
            phyReqValid_q <= 1'b1;                  // [R04] [R05]
            // Read takes precedence if both were ever set
            phyReqWrite_q <= !rdReq_q;              // [R06]
            phyReqAddr_q <= tgtAddr_q;
            phyReqData_q <= rdReq_q ? 8'h00 : wrVal_q; // [R07]
        end
    end

    // ****************************************
    // Timer tick divider and cycle pin
    // ****************************************
    reg [`PCT_ACC_W-1:0] acc_q;
    reg [`PCT_ACC_W-1:0] acc_d;
    reg tick_q;
    reg tick_d;
    // Fractional divider: mean rate exact, tick jitter one system clock
    always @* begin
        acc_d = acc_q + `PCT_TMR_KHZ;
        tick_d = 1'b0;
        if (acc_d >= `PCT_SYS_KHZ) begin
            acc_d = acc_d - `PCT_SYS_KHZ;
            tick_d = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= {`PCT_ACC_W{1'b0}};
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    reg cycMeta_q;
    reg cycSync_q;
    reg cycPrev_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycMeta_q <= 1'b0;
            cycSync_q <= 1'b0;
            cycPrev_q <= 1'b0;
        end else begin
            cycMeta_q <= externalCycleInput;
            cycSync_q <= cycMeta_q;
            cycPrev_q <= cycSync_q;
        end
    end

    wire extTick = externalCycleSelect && cycSync_q && !cycPrev_q;

    // ****************************************
    // Cycle timer
    // ****************************************
    wire [`PCT_SEC_W-1:0] secCnt;
    wire [`PCT_CYC_W-1:0] cycCnt;
    wire [`PCT_OFF_W-1:0] offCnt;
    wire cycLast;
    wire offLast;
    wire rxLoad = cycStartRxValid && !cycleMasterEnable;   // [R13]
    wire tmrLoad = wrTimer || rxLoad;
    wire [31:0] tmrLoadVal = wrTimer ? regWrData : cycStartRxData;

    // Under the pin the offset parks at its last value awaiting the tick
    wire offInc = tick_q && cycleTimerEnable &&            // [R14]
        !(externalCycleSelect && offLast);                 // [R21]
    wire offRoll = externalCycleSelect ? extTick :         // [R21]
        (offInc && offLast);                               // [R10]
    wire cycRoll = offRoll && cycLast;

    pct_wrap_counter #(.WIDTH(`PCT_OFF_W), .LAST(`PCT_OFF_LAST)) uOffset (
        .clk(clk), .rst_n(rst_n),
        .incEn(offInc),                                    // [R10]
        .loadEn(tmrLoad || extTick),                       // [R11]
        .loadVal(tmrLoad ? tmrLoadVal[`PCT_F_OFF] : `PCT_OFF_ZERO),
        .count_q(offCnt),
        .lastHit(offLast)
    );
    pct_wrap_counter #(.WIDTH(`PCT_CYC_W), .LAST(`PCT_CYC_LAST)) uCycles (
        .clk(clk), .rst_n(rst_n),
        .incEn(offRoll),                                   // [R09]
        .loadEn(tmrLoad),
        .loadVal(tmrLoadVal[`PCT_F_CYC]),
        .count_q(cycCnt),
        .lastHit(cycLast)
    );
    pct_wrap_counter #(.WIDTH(`PCT_SEC_W), .LAST(`PCT_SEC_LAST)) uSeconds (
        .clk(clk), .rst_n(rst_n),
        .incEn(cycRoll),                                   // [R08]
        .loadEn(tmrLoad),
        .loadVal(tmrLoadVal[`PCT_F_SEC]),
        .count_q(secCnt),
        .lastHit()
    );

    wire [31:0] timerNow = {secCnt, cycCnt, offCnt};

    // Sample one clock after rollover so the sent value shows the new cycle
    reg rollDly_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rollDly_q <= 1'b0;
            cycStartTxValid_q <= 1'b0;
            cycStartTxData_q <= `PCT_WORD_ZERO;
        end else begin
            rollDly_q <= offRoll && !tmrLoad;
            cycStartTxValid_q <= rollDly_q && cycleMasterEnable;
            if (rollDly_q && cycleMasterEnable) begin
                cycStartTxData_q <= timerNow;               // [R12]
            end
        end
    end

    // ****************************************
    // Async request filter
    // ****************************************
    reg [31:0] hiFilt_q;
    reg [31:0] loFilt_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hiFilt_q <= `PCT_WORD_ZERO;
            loFilt_q <= `PCT_WORD_ZERO;
        end else begin
            if (wrHiSet) begin
                hiFilt_q <= hiFilt_q | regWrData;           // [R19] [R20]
            end else if (wrHiClr) begin
                hiFilt_q <= hiFilt_q & ~regWrData;          // [R19] [R20]
            end
            if (wrLoSet) begin
                loFilt_q <= loFilt_q | regWrData;           // [R19] [R20]
            end else if (wrLoClr) begin
                loFilt_q <= loFilt_q & ~regWrData;          // [R19] [R20]
            end
        end
    end

    wire [9:0] srcBus = filtSrcId[15:6];
    wire [5:0] srcNode = filtSrcId[5:0];
    wire srcLocal = (srcBus == localBusNumber) ||
        (srcBus == `PCT_LOCAL_BUS);
    reg admit;
    always @* begin
        admit = 1'b1;
        if (!filtCtxHit) begin
            admit = 1'b1;
        end else if (!srcLocal) begin
            admit = hiFilt_q[`PCT_B_ALLBUS];                // [R16]
        end else if (!srcNode[5]) begin
            admit = loFilt_q[srcNode[4:0]];                 // [R18] [R15]
        end else if (srcNode != `PCT_NODE_BCAST) begin
            admit = hiFilt_q[srcNode[4:0]];                 // [R17] [R15]
        end else begin
            admit = 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filtDoneValid_q <= 1'b0;
            filtAccept_q <= 1'b0;
        end else begin
            filtDoneValid_q <= filtReqValid;
            if (filtReqValid) begin
                filtAccept_q <= admit;                      // [R15]
            end
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    reg [31:0] rdMux;
    always @* begin
        rdMux = `PCT_WORD_ZERO;
        case (target_phy_reg_address)
            `PCT_A_PHY: begin
                rdMux[`PCT_B_DONE] = done_q;
                rdMux[`PCT_F_RETA] = retAddr_q;
                rdMux[`PCT_F_RETV] = retData_q;
                rdMux[`PCT_B_RDREQ] = rdReq_q;
                rdMux[`PCT_B_WRREQ] = wrReq_q;
                rdMux[`PCT_F_TADDR] = tgtAddr_q;
                rdMux[`PCT_F_WDATA] = wrVal_q;
            end
            `PCT_A_TIMER: rdMux = timerNow;
            `PCT_A_HI_SET, `PCT_A_HI_CLR: rdMux = hiFilt_q;     // [R20]
            `PCT_A_LO_SET, `PCT_A_LO_CLR: rdMux = loFilt_q;     // [R20]
            default: rdMux = `PCT_WORD_ZERO;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_q <= `PCT_WORD_ZERO;
            regRdValid_q <= 1'b0;
        end else begin
            regRdValid_q <= regRdEn;
            if (regRdEn) begin
                regRdData_q <= rdMux;
            end
        end
    end

endmodule

`default_nettype wire

// >>> pct_consts.vh
// Constants shared by the PHY access, cycle timer and request filter bank.
// Assumes inclusion by bare name from the bank, its checker and its bench.
`ifndef PCT_CONSTS_VH
`define PCT_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define PCT_ADDR_W 9
`define PCT_A_PHY 9'h0ec
`define PCT_A_TIMER 9'h0f0
`define PCT_A_HI_SET 9'h100
`define PCT_A_HI_CLR 9'h104
`define PCT_A_LO_SET 9'h108
`define PCT_A_LO_CLR 9'h10c

// ****************************************
// PHY access register fields
// ****************************************
`define PCT_B_DONE 31
`define PCT_F_RETA 27:24
`define PCT_F_RETV 23:16
`define PCT_B_RDREQ 15
`define PCT_B_WRREQ 14
`define PCT_F_TADDR 11:8
`define PCT_F_WDATA 7:0

// ****************************************
// Cycle timer fields and limits
// ****************************************
`define PCT_F_SEC 31:25
`define PCT_F_CYC 24:12
`define PCT_F_OFF 11:0
`define PCT_SEC_W 7
`define PCT_CYC_W 13
`define PCT_OFF_W 12
`define PCT_SEC_LAST 7'h7f
`define PCT_CYC_LAST 13'h1f3f
`define PCT_OFF_LAST 12'hbff
`define PCT_OFF_ZERO 12'h000

// ****************************************
// Timer tick divider (rates in kHz)
// ****************************************
`define PCT_ACC_W 17
`define PCT_SYS_KHZ 17'h186a0
`define PCT_TMR_KHZ 17'h06000

// ****************************************
// Request filter
// ****************************************
`define PCT_B_ALLBUS 31
`define PCT_LOCAL_BUS 10'h3ff
`define PCT_NODE_BCAST 6'h3f
`define PCT_WORD_ZERO 32'h00000000

`endif

// >>> pct_wrap_counter.v
// Wrapping counter with a synchronous load, one field of the cycle timer.
// Assumes the caller gates increments and flags the wrap from lastHit.
`default_nettype none

module pct_wrap_counter #(
    parameter WIDTH = 12,
    parameter [WIDTH-1:0] LAST = {WIDTH{1'b1}}
) (
    input wire clk,                  // System clock
    input wire rst_n,                // Async reset, active low
    input wire incEn,                // Count one step
    input wire loadEn,               // Load wins over count
    input wire [WIDTH-1:0] loadVal,  // Value to load
    output reg [WIDTH-1:0] count_q,  // Current count
    output wire lastHit              // Count sits at its last value
);

    assign lastHit = (count_q == LAST);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {WIDTH{1'b0}};
        end else if (loadEn) begin
            count_q <= loadVal;
        end else if (incEn) begin
            if (lastHit) begin
                count_q <= {WIDTH{1'b0}};
            end else begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// >>> pct_access_bank_checker.sv
// Port assertions for the PHY access, cycle timer and filter bank.
// Assumes it is bound into every pct_access_bank instance.
`default_nettype none
`include "pct_consts.vh"
module pct_access_bank_checker (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic regWrEn, // Write strobe
    input wire logic regRdEn, // Read strobe
    input wire logic [8:0] target_phy_reg_address, // Address
    input wire logic [31:0] regWrData, // Write data
    input wire logic regRdValid_q, // Read valid
    input wire logic phyReqValid_q, // PHY request
    input wire logic phyReqReady, // PHY takes it
    input wire logic phyReqWrite_q, // Write kind
    input wire logic [3:0] phyReqAddr_q, // PHY address
    input wire logic [7:0] phyReqData_q, // PHY data
    input wire logic cycStartTxValid_q, // Cycle start out
    input wire logic [31:0] cycStartTxData_q, // Its data
    input wire logic filtReqValid, // Filter check
    input wire logic filtCtxHit, // Filtered context
    input wire logic [15:0] filtSrcId, // Source ID
    input wire logic [9:0] localBusNumber, // Own bus
    input wire logic filtDoneValid_q, // Decision valid
    input wire logic filtAccept_q // Accept
);
    // ****************
    // Port properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Only fresh requests: a pending one may still be in flight
    wire logic phyWr = regWrEn && target_phy_reg_address == `PCT_A_PHY && !phyReqValid_q;

    a_read_issue:
        assert property (phyWr && regWrData[15] |-> ##2 phyReqValid_q &&
            !phyReqWrite_q && phyReqAddr_q == $past(regWrData[11:8], 2))
        else $error("PHY read not issued");
    a_write_issue:
        assert property (phyWr && regWrData[14] && !regWrData[15] |-> ##2
            phyReqValid_q && phyReqWrite_q &&
            phyReqData_q == $past(regWrData[7:0], 2))
        else $error("PHY write not issued");
    a_request_holds:
        assert property (phyReqValid_q && !phyReqReady |=> phyReqValid_q &&
            $stable(phyReqWrite_q) && $stable(phyReqAddr_q))
        else $error("PHY request dropped early");
    a_request_ends:
        assert property (phyReqValid_q && phyReqReady |=> !phyReqValid_q)
        else $error("PHY request not cleared");
    a_read_no_data:
        assert property (phyReqValid_q && !phyReqWrite_q |->
            phyReqData_q == 8'h00)
        else $error("PHY read carries data");
    a_start_offset:
        assert property (cycStartTxValid_q |->
            cycStartTxData_q[11:0] == 12'h000)
        else $error("cycle start offset not zero");
    a_ctx_bypass:
        assert property (filtReqValid && !filtCtxHit |=>
            filtDoneValid_q && filtAccept_q)
        else $error("unfiltered packet refused");
    a_node_reject:
        assert property (filtReqValid && filtCtxHit && filtSrcId[5:0] ==
            6'h3f && (filtSrcId[15:6] == localBusNumber ||
            filtSrcId[15:6] == 10'h3ff) |=> filtDoneValid_q && !filtAccept_q)
        else $error("broadcast source accepted");
    a_read_answer:
        assert property (regRdValid_q == $past(regRdEn))
        else $error("read answer mistimed");
    c_phy_write: cover property (phyReqValid_q && phyReqReady && phyReqWrite_q);
    c_cycle_start: cover property (cycStartTxValid_q);
    c_filter_drop: cover property (filtDoneValid_q && !filtAccept_q);
endmodule

bind pct_access_bank pct_access_bank_checker pct_access_bank_checker_inst (.*);
`default_nettype wire

// >>> pct_phy_model.sv
// PHY stand-in: accepts register requests, answers reads with a transfer.
// Assumes requests are held until taken; alternates prompt and slow takes.
`default_nettype none
module pct_phy_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic reqValid, // Request pending
    output logic reqReady, // Request taken
    input wire logic reqWrite, // Write, else read
    input wire logic [3:0] reqAddr, // Register address
    output logic retValid, // Transfer back
    output logic [3:0] retAddr, // Returned address
    output logic [7:0] retData // Returned value
);
    logic [1:0] waitCnt;
    logic slow;
    logic [3:0] pendAddr;
    logic [2:0] retDelay;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {reqReady, retValid, slow, waitCnt, retDelay} <= 8'h00;
            {pendAddr, retAddr, retData} <= 16'h0000;
        end else begin
            reqReady <= 1'h0;
            retValid <= 1'h0;
            // Idle return lines churn so stale values never look valid
            retAddr <= ~retAddr;
            retData <= ~retData;
            if (reqValid && !reqReady) begin
                if (waitCnt == (slow ? 2'h3 : 2'h0)) begin
                    reqReady <= 1'h1;
                    waitCnt <= 2'h0;
                    slow <= ~slow;
                    pendAddr <= reqAddr;
                    retDelay <= reqWrite ? 3'h0 : 3'h5;
                end else begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
            if (retDelay != 3'h0) begin
                retDelay <= retDelay - 3'h1;
            end
            if (retDelay == 3'h1) begin
                retValid <= 1'h1;
                retAddr <= pendAddr;
                retData <= {4'hc, pendAddr};
            end
        end
    end
endmodule
`default_nettype wire

// >>> pct_access_bank_tb_top.sv
// Self-checking bench for the PHY access, cycle timer and filter bank.
// Assumes the PHY stand-in on the far side; inputs move at falling edges.
`default_nettype none
`include "pct_consts.vh"
module pct_access_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0;
    logic [8:0] target_phy_reg_address = 9'h000;
    logic [31:0] regWrData = 32'h0, cycStartRxData = 32'h0, rdVal;
    logic cycleMasterEnable = 1'h0, externalCycleSelect = 1'h0;
    logic cycleTimerEnable = 1'h0, externalCycleInput = 1'h0;
    logic cycStartRxValid = 1'h0, filtReqValid = 1'h0, filtCtxHit = 1'h0;
    logic [9:0] localBusNumber = 10'h005;
    logic [15:0] filtSrcId = 16'h0;
    wire logic [31:0] regRdData_q, cycStartTxData_q;
    wire logic regRdValid_q, phyReqValid_q, phyReqReady, phyReqWrite_q;
    wire logic phyRetValid, cycStartTxValid_q, filtDoneValid_q, filtAccept_q;
    wire logic [3:0] phyReqAddr_q, phyRetAddr;
    wire logic [7:0] phyReqData_q, phyRetData;
    int failures = 0, checked = 0, n;

    always #5 clk = ~clk;

    pct_access_bank pct_access_bank_inst (.*);
    pct_phy_model pct_phy_model_inst (.clk(clk), .rst_n(rst_n),
        .reqValid(phyReqValid_q), .reqReady(phyReqReady),
        .reqWrite(phyReqWrite_q), .reqAddr(phyReqAddr_q),
        .retValid(phyRetValid), .retAddr(phyRetAddr), .retData(phyRetData));

    // ****************
    // Helper tasks
    // ****************
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic timeout(input string name);
        check(name, 32'h0, 32'h1);
        stop_test();
    endtask
    task automatic regWrite(input logic [8:0] a, input logic [31:0] d);
        @(negedge clk);
        {regWrEn, target_phy_reg_address, regWrData} = {1'h1, a, d};
        @(negedge clk);
        regWrEn = 1'h0;
    endtask
    task automatic regRead(input logic [8:0] a);
        @(negedge clk);
        {regRdEn, target_phy_reg_address} = {1'h1, a};
        @(negedge clk);
        regRdEn = 1'h0;
        check("read valid", 32'(regRdValid_q), 32'h1);
        rdVal = regRdData_q;
    endtask
    task automatic expectReg(input logic [8:0] a, input logic [31:0] exp);
        regRead(a);
        check($sformatf("register %h", a), rdVal, exp);
    endtask
    task automatic waitReg(input logic [8:0] a, input logic [31:0] m,
        input logic [31:0] v);
        for (n = 0; n < 40; n++) begin
            regRead(a);
            if ((rdVal & m) === v)
                return;
        end
        timeout("register wait");
    endtask
    task automatic filt(input logic ctx, input logic [15:0] src,
        input logic exp);
        @(negedge clk);
        {filtReqValid, filtCtxHit, filtSrcId} = {1'h1, ctx, src};
        @(negedge clk);
        filtReqValid = 1'h0;
        check("filter done", 32'(filtDoneValid_q), 32'h1);
        check("filter accept", 32'(filtAccept_q), 32'(exp));
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        expectReg(`PCT_A_HI_SET, 32'h0);
        expectReg(`PCT_A_LO_CLR, 32'h0);
        regWrite(9'h0f4, 32'hffffffff);
        expectReg(9'h0f4, 32'h0);
        regWrite(`PCT_A_HI_SET, 32'h80000005);
        regWrite(`PCT_A_HI_CLR, 32'h00000001);
        regWrite(`PCT_A_HI_SET, 32'h0);
        expectReg(`PCT_A_HI_CLR, 32'h80000004);
        regWrite(`PCT_A_LO_SET, 32'h00000003);
        regWrite(`PCT_A_LO_CLR, 32'h00000001);
        expectReg(`PCT_A_LO_SET, 32'h00000002);
        filt(1'h1, {10'h005, 6'h01}, 1'h1);
        filt(1'h1, {10'h005, 6'h00}, 1'h0);
        filt(1'h1, {10'h005, 6'h22}, 1'h1);
        filt(1'h1, {10'h005, 6'h20}, 1'h0);
        filt(1'h1, {10'h005, 6'h3f}, 1'h0);
        filt(1'h1, {10'h007, 6'h00}, 1'h1);
        filt(1'h1, {10'h3ff, 6'h01}, 1'h1);
        filt(1'h0, {10'h005, 6'h00}, 1'h1);
        regWrite(`PCT_A_HI_CLR, 32'h80000000);
        filt(1'h1, {10'h007, 6'h01}, 1'h0);
        // One request kind at a time from software
        regWrite(`PCT_A_PHY, 32'h000085aa);
        waitReg(`PCT_A_PHY, 32'h80000000, 32'h80000000);
        expectReg(`PCT_A_PHY, 32'h85c505aa);
        regWrite(`PCT_A_PHY, 32'h00004377);
        regRead(`PCT_A_PHY);
        check("done cleared", rdVal & 32'h80000000, 32'h0);
        waitReg(`PCT_A_PHY, 32'h00004000, 32'h0);
        regWrite(`PCT_A_PHY, 32'h8fff0312);
        expectReg(`PCT_A_PHY, 32'h05c50312);
        cycleTimerEnable = 1'h1;
        regWrite(`PCT_A_TIMER, {7'h7f, 13'h1f3f, 12'hbf0});
        repeat (200) @(negedge clk);
        regRead(`PCT_A_TIMER);
        check("timer wrap", rdVal & 32'hfffff000, 32'h0);
        check("offset", 32'(rdVal[11:0] > 12'h01c && rdVal[11:0] < 12'h027),
            32'h1);
        cycleTimerEnable = 1'h0;
        cycStartRxData = {7'h09, 13'h0123, 12'h456};
        cycStartRxValid = 1'h1;
        @(negedge clk);
        {cycStartRxValid, cycleMasterEnable} = 2'h1;
        expectReg(`PCT_A_TIMER, {7'h09, 13'h0123, 12'h456});
        cycStartRxData = 32'h0;
        cycStartRxValid = 1'h1;
        @(negedge clk);
        cycStartRxValid = 1'h0;
        expectReg(`PCT_A_TIMER, {7'h09, 13'h0123, 12'h456});
        cycleTimerEnable = 1'h1;
        regWrite(`PCT_A_TIMER, {7'h01, 13'h0010, 12'hbfa});
        for (n = 0; n < 100 && cycStartTxValid_q !== 1'h1; n++)
            @(negedge clk);
        if (cycStartTxValid_q !== 1'h1)
            timeout("cycle start");
        check("cycle start", cycStartTxData_q,
            {7'h01, 13'h0011, 12'h000});
        {cycleMasterEnable, externalCycleSelect} = 2'h1;
        regWrite(`PCT_A_TIMER, {7'h00, 13'h0005, 12'hbf0});
        repeat (300) @(negedge clk);
        expectReg(`PCT_A_TIMER, {7'h00, 13'h0005, 12'hbff});
        externalCycleInput = 1'h1;
        repeat (6) @(negedge clk);
        regRead(`PCT_A_TIMER);
        check("external tick", rdVal & 32'hffffff00,
            {7'h00, 13'h0006, 12'h000});
        stop_test();
    end
endmodule
`default_nettype wire
